// ===== hw/pom_mgmt.sv
// Functional notes
// - laser fault disables laser, fault flag high
// - transmitter on only while off input low
// - no light flag high below sensitivity
// - module present pin driven to ground
// - identification over two-wire link, host clocks
// - type information held in identification memory
// - low supply asserts internal reset
// - reset held 140 ms after supply returns
// - laser dark during supervisor reset
// - laser on only after reset timeout
// - no light flag settles within 100 us
`timescale 1ns/1ns
module pom_mgmt
  import pom_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES    = HOLD_CYC,
  parameter int unsigned NO_LIGHT_CYCLES = NO_LIGHT_MAX_CYC,
  parameter logic [6:0]  DEV_ADDR       = 7'h2a  // arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire pom_sense_t  sense,
  output pom_status_t      status,
  output logic             module_present_n_o,
  output logic             module_present_oe_n,
  input  wire logic        id_serial_clock,
  input  wire logic        id_serial_data_i,
  output logic             id_serial_data_o,
  output logic             id_serial_data_oe_n
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [ID_AW-1:0] pom_ptr_inc(input logic [ID_AW-1:0] p);
    pom_ptr_inc = p + 8'h01;
  endfunction : pom_ptr_inc

  // ----------------------------------------------------------------
  // supervisor
  // ----------------------------------------------------------------
  logic [HOLD_CNT_W-1:0] hold_cnt_q;
  logic [HOLD_CNT_W-1:0] hold_cnt_d;
  logic                  sup_rst_q;
  logic                  sup_rst_d;
  // release only once the whole count of good-supply cycles has been seen
  wire                   hold_done = (hold_cnt_q >= HOLD_CNT_W'(HOLD_CYCLES));

  // counter restarts on every dip, so a brownout always earns the full hold
  assign hold_cnt_d = !sense.supply_ok ? '0 :
                      hold_done ? hold_cnt_q : hold_cnt_q + HOLD_CNT_W'(1);
  assign sup_rst_d  = !sense.supply_ok | !hold_done;

  always_ff @(posedge clk) begin
    if (srst) begin
      hold_cnt_q <= '0;
      sup_rst_q  <= SUP_RST_RST;
    end else begin
      hold_cnt_q <= hold_cnt_d;
      sup_rst_q  <= sup_rst_d;
    end
  end

  // ----------------------------------------------------------------
  // laser fault and enable
  // ----------------------------------------------------------------
  logic fault_q;
  logic fault_d;
  logic laser_en_d;

  // fault latches; cleared only by an off request or supervisor reset
  assign fault_d    = sense.laser_fault | (fault_q & ~sense.tx_off & ~sup_rst_q);
  assign laser_en_d = ~sense.tx_off & ~fault_d & ~sup_rst_d;

  always_ff @(posedge clk) begin
    if (srst) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_d;
    end
  end

  // ----------------------------------------------------------------
  // no light filter
  // ----------------------------------------------------------------
  logic [FILT_CNT_W-1:0] filt_cnt_q;
  logic [FILT_CNT_W-1:0] filt_cnt_d;
  logic                  no_light_d;
  // half the bound: rejects glitches yet leaves margin to the limit
  wire                   filt_done = (filt_cnt_q >= FILT_CNT_W'(NO_LIGHT_CYCLES / 2));
  wire                   filt_diff = (sense.rx_power_low != status.no_light_flag);

  assign filt_cnt_d = !filt_diff ? '0 : filt_cnt_q + FILT_CNT_W'(1);
  assign no_light_d = (filt_diff & filt_done) ? sense.rx_power_low
                                              : status.no_light_flag;

  always_ff @(posedge clk) begin
    if (srst) begin
      filt_cnt_q <= '0;
    end else begin
      filt_cnt_q <= filt_done ? '0 : filt_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // status pins
  // ----------------------------------------------------------------
  // no light reads high from reset: nothing has been seen yet
  always_ff @(posedge clk) begin
    if (srst) begin
      status              <= '{1'b0, 1'b0, 1'b1, SUP_RST_RST};
      module_present_n_o  <= DRIVE_LOW;
      module_present_oe_n <= DRIVE_LOW;
    end else begin
      status.laser_enable     <= laser_en_d;
      status.laser_fault_flag <= fault_d;
      status.no_light_flag    <= no_light_d;
      status.supervisor_reset <= sup_rst_d;
      module_present_n_o      <= DRIVE_LOW;
      module_present_oe_n     <= DRIVE_LOW;
    end
  end

  // ----------------------------------------------------------------
  // two-wire identification slave
  // ----------------------------------------------------------------
  logic             scl_q;
  logic             sda_q;
  pom_state_t       st_q;
  pom_state_t       st_d;
  logic [3:0]       cnt_q;
  logic [7:0]       sr_q;
  logic             rw_q;
  logic [ID_AW-1:0] ptr_q;
  logic             oe_n_q;
  logic [7:0]       id_mem_q [ID_DEPTH];

  // line events, taken on the host-driven clock level
  wire scl_rise  = id_serial_clock & ~scl_q;
  wire scl_fall  = ~id_serial_clock & scl_q;
  wire start_det = id_serial_clock & scl_q & sda_q & ~id_serial_data_i;
  wire stop_det  = id_serial_clock & scl_q & ~sda_q & id_serial_data_i;
  wire byte_full = (cnt_q == BIT_CNT_FULL);
  wire addr_hit  = (sr_q[7:1] == DEV_ADDR);
  wire rx_state  = (st_q == ST_ADDR) | (st_q == ST_WORD) | (st_q == ST_WDAT);
  wire [7:0] rd_byte = id_mem_q[ptr_q];
  wire mem_we    = scl_fall & byte_full & (st_q == ST_WDAT);

  // next state; start and stop override from any state
  always_comb begin
    st_d = st_q;
    if (start_det) begin
      st_d = ST_ADDR;
    end else if (stop_det) begin
      st_d = ST_IDLE;
    end else if (scl_fall) begin
      unique case (st_q)
        ST_IDLE: st_d = ST_IDLE;
        ST_ADDR: st_d = byte_full ? (addr_hit ? ST_AACK : ST_IDLE) : ST_ADDR;
        ST_AACK: st_d = rw_q ? ST_RDAT : ST_WORD;
        ST_WORD: st_d = byte_full ? ST_WACK : ST_WORD;
        ST_WACK: st_d = ST_WDAT;
        ST_WDAT: st_d = byte_full ? ST_DACK : ST_WDAT;
        ST_DACK: st_d = ST_WDAT;
        ST_RDAT: st_d = byte_full ? ST_RACK : ST_RDAT;
        ST_RACK: st_d = ST_RDAT;
        default: st_d = ST_IDLE;
      endcase
    end else if (scl_rise & (st_q == ST_RACK) & id_serial_data_i) begin
      st_d = ST_IDLE;  // host declined further bytes
    end
  end

  // edge history
  always_ff @(posedge clk) begin
    if (srst) begin
      scl_q <= RELEASE;
      sda_q <= RELEASE;
      st_q  <= ST_IDLE;
    end else begin
      scl_q <= id_serial_clock;
      sda_q <= id_serial_data_i;
      st_q  <= st_d;
    end
  end

  // bit counter and shift register
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= BIT_CNT_RST;
      sr_q  <= '0;
      rw_q  <= 1'b0;
    end else if (start_det) begin
      cnt_q <= BIT_CNT_RST;
    end else if (scl_rise & (rx_state | (st_q == ST_RDAT))) begin
      cnt_q <= cnt_q + 4'h1;
      sr_q  <= rx_state ? {sr_q[6:0], id_serial_data_i} : sr_q;
    end else if (scl_fall) begin
      if (byte_full | (st_q == ST_AACK) | (st_q == ST_WACK) | (st_q == ST_DACK)) begin
        cnt_q <= BIT_CNT_RST;
      end
      if ((st_q == ST_ADDR) & byte_full) begin
        rw_q <= sr_q[0];
      end
      if ((st_d == ST_RDAT) & (st_q != ST_RDAT)) begin
        sr_q <= rd_byte;
      end else if (st_q == ST_RDAT) begin
        sr_q <= {sr_q[6:0], 1'b0};
      end
    end
  end

  // pointer: set by word byte, advances after each data byte
  always_ff @(posedge clk) begin
    if (srst) begin
      ptr_q <= PTR_RST;
    end else if (scl_fall & byte_full & (st_q == ST_WORD)) begin
      ptr_q <= sr_q;
    end else if (scl_fall & byte_full & ((st_q == ST_WDAT) | (st_q == ST_RDAT))) begin
      ptr_q <= pom_ptr_inc(ptr_q);
    end
  end

  // identification storage; flops stand in for the nonvolatile array
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < ID_DEPTH; i++) begin
        id_mem_q[i] <= ID_MEM_RST;
      end
    end else if (mem_we) begin
      id_mem_q[ptr_q] <= sr_q;
    end
  end

  // data pin drive, changes on a falling clock edge; released on start or stop
  wire ack_next  = (st_d == ST_AACK) | (st_d == ST_WACK) | (st_d == ST_DACK);
  wire load_next = (st_d == ST_RDAT) & (st_q != ST_RDAT);

  always_ff @(posedge clk) begin
    if (srst) begin
      oe_n_q <= RELEASE;
    end else if (start_det | stop_det) begin
      oe_n_q <= RELEASE;
    end else if (scl_fall) begin
      if (ack_next) begin
        oe_n_q <= DRIVE_LOW;
      end else if (load_next) begin
        oe_n_q <= rd_byte[7];
      end else if ((st_q == ST_RDAT) & ~byte_full & (st_d == ST_RDAT)) begin
        oe_n_q <= sr_q[6];
      end else begin
        oe_n_q <= RELEASE;
      end
    end
  end

  // open drain: the pin only ever pulls low
  always_ff @(posedge clk) begin
    if (srst) begin
      id_serial_data_o <= DRIVE_LOW;
    end else begin
      id_serial_data_o <= DRIVE_LOW;
    end
  end

  assign id_serial_data_oe_n = oe_n_q;

endmodule : pom_mgmt

// ===== hw/pom_pkg.sv
package pom_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ            = 50_000_000;
  localparam int unsigned HOLD_TIME_MS      = 140;
  localparam int unsigned HOLD_CYC          = (HOLD_TIME_MS * (CLK_HZ / 1000));
  localparam int unsigned NO_LIGHT_MAX_US   = 100;
  localparam int unsigned NO_LIGHT_MAX_CYC  = (NO_LIGHT_MAX_US * (CLK_HZ / 1_000_000));
  localparam int unsigned HOLD_CNT_W        = 23;
  localparam int unsigned FILT_CNT_W        = 13;

  // ----------------------------------------------------------------
  // identification memory and serial link
  // ----------------------------------------------------------------
  localparam int unsigned ID_DEPTH          = 256;
  localparam int unsigned ID_AW             = 8;
  localparam logic [3:0]  BIT_CNT_FULL      = 4'h8;
  localparam logic [3:0]  BIT_CNT_RST       = 4'h0;
  localparam logic [7:0]  ID_MEM_RST        = 8'h00;
  localparam logic [7:0]  PTR_RST           = 8'h00;

  // ----------------------------------------------------------------
  // reset values of pins
  // ----------------------------------------------------------------
  localparam logic        TX_OFF_RST        = 1'b1;
  localparam logic        SUP_RST_RST       = 1'b1;
  localparam logic        RELEASE           = 1'b1;
  localparam logic        DRIVE_LOW         = 1'b0;

  // serial slave states
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_AACK  = 9'h004,
    ST_WORD  = 9'h008,
    ST_WACK  = 9'h010,
    ST_WDAT  = 9'h020,
    ST_DACK  = 9'h040,
    ST_RDAT  = 9'h080,
    ST_RACK  = 9'h100
  } pom_state_t;

  // supervision inputs from the analog front end
  typedef struct packed {
    logic tx_off;        // transmitter_off_input level
    logic laser_fault;   // automatic shutdown circuit fault detect
    logic supply_ok;     // supply above supply_reset_threshold
    logic rx_power_low;  // received power below sensitivity
  } pom_sense_t;

  // supervision outputs
  typedef struct packed {
    logic laser_enable;
    logic laser_fault_flag;
    logic no_light_flag;
    logic supervisor_reset;
  } pom_status_t;

endpackage : pom_pkg

// ===== dv/pom_checker.sv
`timescale 1ns/1ns
module pom_checker
  import pom_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES     = 20,
  parameter int unsigned NO_LIGHT_CYCLES = 20
) (
  input wire logic        clk,
  input wire logic        srst,
  input wire pom_sense_t  sense,
  input wire pom_status_t status,
  input wire logic        module_present_n_o,
  input wire logic        module_present_oe_n,
  input wire logic        id_serial_clock,
  input wire logic        id_serial_data_i,
  input wire logic        id_serial_data_o,
  input wire logic        id_serial_data_oe_n
);
  logic [15:0] ok_q;
  logic [15:0] dis_q;
  // run lengths of good supply and of flag disagreement; ok_q saturates
  always_ff @(posedge clk) begin
    ok_q  <= (srst || !sense.supply_ok) ? 16'h0000 : ok_q + {15'h0000, ~&ok_q};
    dis_q <= (srst || sense.rx_power_low == status.no_light_flag) ? 16'h0000 : dis_q + 16'h0001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_off_req: assert property (sense.tx_off |=> !status.laser_enable)
    else $error("laser on under off request");
  a_fault_dark: assert property (sense.laser_fault |=> status.laser_fault_flag && !status.laser_enable)
    else $error("fault not flagged");
  a_dip_reset: assert property (!sense.supply_ok |=> status.supervisor_reset && !status.laser_enable)
    else $error("low supply without reset");
  a_reset_dark: assert property (status.supervisor_reset |-> !status.laser_enable)
    else $error("laser on during reset");
  a_hold_min: assert property ($fell(status.supervisor_reset) |-> ok_q > HOLD_CYCLES)
    else $error("reset released early");
  a_hold_max: assert property (ok_q == HOLD_CYCLES + 3 |-> !status.supervisor_reset)
    else $error("reset released late");
  a_light_dir: assert property ($changed(status.no_light_flag) |-> status.no_light_flag == $past(sense.rx_power_low))
    else $error("flag moved against input");
  a_light_time: assert property (dis_q <= NO_LIGHT_CYCLES)
    else $error("flag too slow");
  a_enable_and: assert property (status.laser_enable |-> !$past(sense.tx_off) && !$past(sense.laser_fault) && !status.laser_fault_flag)
    else $error("enable without all conditions");
  a_present_gnd: assert property (!module_present_n_o && !module_present_oe_n)
    else $error("present pin not grounded");
  a_sda_open: assert property ($changed(id_serial_data_oe_n) |-> !id_serial_clock && !id_serial_data_o)
    else $error("data line moved with clock high");
endmodule : pom_checker

bind pom_mgmt pom_checker #(.HOLD_CYCLES(HOLD_CYCLES), .NO_LIGHT_CYCLES(NO_LIGHT_CYCLES)) i_pom_checker (
  .clk(clk), .srst(srst), .sense(sense), .status(status),
  .module_present_n_o(module_present_n_o), .module_present_oe_n(module_present_oe_n),
  .id_serial_clock(id_serial_clock), .id_serial_data_i(id_serial_data_i),
  .id_serial_data_o(id_serial_data_o), .id_serial_data_oe_n(id_serial_data_oe_n));

// ===== dv/pom_host.sv
`timescale 1ns/1ns
module pom_host (
  input  wire logic clk,
  input  wire logic sda_oe_n,
  output logic      scl,
  output logic      sda_wire
);
  logic drv;
  // open-drain line with board pull-up: released reads high
  assign sda_wire = drv & (sda_oe_n !== 1'b0);
  initial begin
    scl = 1'b1;
    drv = 1'b1;
  end
  // one bus phase; slow so the slave sees each level several cycles
  task automatic ph(input logic c, input logic d);
    repeat (4) @(posedge clk);
    scl <= c;
    drv <= d;
  endtask : ph
  // data set while clock low, sampled three cycles into the seven-cycle high phase
  task automatic bit_io(input logic d, output logic q);
    ph(1'b0, drv);
    ph(1'b0, d);
    ph(1'b1, d);
    repeat (3) @(posedge clk);
    q = sda_wire;
  endtask : bit_io
  // eight bits msb first, then the acknowledge slot
  task automatic byte_io(input logic [8:0] w, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      bit_io(w[i], r[i]);
    end
  endtask : byte_io
  task automatic start();
    ph(1'b0, drv);
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
  endtask : start
  task automatic stop();
    ph(1'b0, drv);
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask : stop
endmodule : pom_host

// ===== dv/tb_pom_mgmt.sv
`timescale 1ns/1ns
module tb_pom_mgmt
  import pom_pkg::*;
;
  localparam int unsigned HOLD = 20;
  localparam int unsigned NLC  = 20;
  localparam logic [6:0]  ADDR = 7'h2a; // arbitrary
  logic        clk, srst, scl, sda, pres_n, pres_oe_n, sda_o, sda_oe_n, chk_on, exp_q, flt_m;
  pom_sense_t  sense;
  pom_status_t status;
  logic [31:0] rng;
  logic [8:0]  r;
  logic [7:0]  d0, d1;
  int          num_errors, samples_checked, cyc;
  pom_mgmt #(.HOLD_CYCLES(HOLD), .NO_LIGHT_CYCLES(NLC), .DEV_ADDR(ADDR)) i_pom_mgmt (
    .clk(clk), .srst(srst), .sense(sense), .status(status),
    .module_present_n_o(pres_n), .module_present_oe_n(pres_oe_n),
    .id_serial_clock(scl), .id_serial_data_i(sda),
    .id_serial_data_o(sda_o), .id_serial_data_oe_n(sda_oe_n));
  pom_host i_pom_host (.clk(clk), .sda_oe_n(sda_oe_n), .scl(scl), .sda_wire(sda));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  // laser follows off request, fault input and latched flag
  function automatic logic exp_laser(input pom_sense_t s, input logic f);
    return ~s.tx_off & ~s.laser_fault & ~f;
  endfunction : exp_laser
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask : tk
  task automatic ck(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : ck
  task automatic wr(input logic [7:0] b);
    i_pom_host.byte_io({b, 1'b1}, r);
    chk("ack", 8'h00, 8'(r[0]));
  endtask : wr
  task automatic rd(input logic last, input logic [7:0] e);
    i_pom_host.byte_io({8'hff, last}, r);
    chk("id byte", e, r[8:1]);
  endtask : rd
  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  // random phase model, compared with pre-edge outputs
  always @(posedge clk) begin
    if (chk_on) begin
      chk("laser", 8'(exp_q), 8'(status.laser_enable));
      chk("fault flag", 8'(flt_m), 8'(status.laser_fault_flag));
      exp_q = exp_laser(sense, flt_m);
      flt_m = sense.laser_fault | (flt_m & ~sense.tx_off);
    end
  end
  // hang guard, far above the few thousand cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  initial begin
    srst = 1'b1;
    sense = '{1'b1, 1'b0, 1'b0, 1'b0};
    chk_on = 1'b0;
    exp_q = 1'b0;
    flt_m = 1'b0;
    num_errors = 0;
    samples_checked = 0;
    cyc = 0;
    rng = 32'h0000e904;
    tk(20);
    srst <= 1'b0;
    ck(1);
    chk("status", 8'h03, 8'(status));
    chk("present", 8'h00, {6'h00, pres_n, pres_oe_n});
    tk(1);
    sense.supply_ok <= 1'b1;
    sense.tx_off <= 1'b0;
    ck(HOLD);
    chk("held", 8'h01, 8'(status));
    ck(1);
    chk("released", 8'h00, 8'(status.supervisor_reset));
    ck(2);
    chk("lit", 8'h01, 8'(status.laser_enable));
    // one-cycle dip must restart the whole hold
    tk(1);
    sense.supply_ok <= 1'b0;
    tk(1);
    sense.supply_ok <= 1'b1;
    ck(1);
    chk("dip", 8'h01, 8'(status));
    ck(HOLD + 2);
    chk("relit", 8'h08, 8'(status));
    tk(1);
    sense.tx_off <= 1'b1;
    ck(2);
    chk("off req", 8'h00, 8'(status));
    // one-cycle fault stays latched until an off request
    tk(1);
    sense.tx_off <= 1'b0;
    sense.laser_fault <= 1'b1;
    tk(1);
    sense.laser_fault <= 1'b0;
    ck(4);
    chk("fault", 8'h04, 8'(status));
    tk(1);
    sense.tx_off <= 1'b1;
    tk(1);
    sense.tx_off <= 1'b0;
    ck(3);
    chk("cleared", 8'h08, 8'(status));
    // short loss is filtered, long loss flagged in time
    tk(1);
    sense.rx_power_low <= 1'b1;
    tk(5);
    sense.rx_power_low <= 1'b0;
    ck(NLC);
    chk("glitch", 8'h00, 8'(status.no_light_flag));
    tk(1);
    sense.rx_power_low <= 1'b1;
    ck(NLC);
    chk("dark", 8'h01, 8'(status.no_light_flag));
    // write two bytes at 5, read back after a repeated start
    rng = xs(rng);
    d0 = rng[7:0];
    d1 = rng[15:8];
    i_pom_host.start();
    wr({ADDR, 1'b0});
    wr(8'h05);
    wr(d0);
    wr(d1);
    i_pom_host.stop();
    i_pom_host.start();
    wr({ADDR, 1'b0});
    wr(8'h05);
    i_pom_host.start();
    wr({ADDR, 1'b1});
    rd(1'b0, d0);
    rd(1'b1, d1);
    i_pom_host.stop();
    i_pom_host.start();
    i_pom_host.byte_io({~ADDR, 1'b0, 1'b1}, r);
    chk("foreign addr", 8'h01, 8'(r[0]));
    i_pom_host.stop();
    tk(1);
    sense.tx_off <= 1'b1;
    tk(2);
    chk_on <= 1'b1;
    for (int i = 0; i < 800; i++) begin
      rng = xs(rng);
      @(posedge clk);
      sense.tx_off <= (rng[3:0] == 4'h0);
      sense.laser_fault <= (rng[8:4] == 5'h00);
      sense.rx_power_low <= sense.rx_power_low ^ (rng[13:9] == 5'h00);
    end
    print_verdict();
  end
endmodule : tb_pom_mgmt
